// File: csac_pkg.sv
// Package for the clock speed and ADC configuration block.
// Assumes a single 200 MHz system clock and a 32-bit classic Wishbone bus.
package csac_pkg;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] SYNC_SERIAL_IO_REG_OFFSET = 4'h4;
  localparam logic [3:0] STATUS_OFFSET = 4'h8;

  // Control register field positions
  localparam int ADC_EXT_BIT   = 0;
  localparam int CLK_SEL_LSB   = 1;
  localparam int CLK_SEL_MSB   = 2;
  localparam int CODEC_SEL_BIT = 3;

  // Serial I/O register field positions
  localparam int CFG_BYTE_MSB = 7;
  localparam int LEN_MSB      = 6;
  localparam int EXT_CFG_LSB  = 16;
  localparam int EXT_CFG_MSB  = 31;

  // Values after reset
  localparam logic [3:0]  CTRL_RESET   = 4'h0;
  localparam logic [31:0] SYNC_SERIAL_IO_REG_RESET = 32'h0000_0000;

  // ADC data length limits in bits
  localparam logic [6:0] LEN_MIN = 7'h08;
  localparam logic [6:0] LEN_MAX = 7'h10;

  // Frequencies in kHz, for reference by the clock generator
  localparam int CPU_KHZ_00 = 18432;
  localparam int CPU_KHZ_01 = 36864;
  localparam int CPU_KHZ_10 = 49152;
  localparam int CPU_KHZ_11 = 73728;
  localparam int BUS_KHZ_LO = 18432;
  localparam int BUS_KHZ_HI = 36864;

  // Wait-state scaling values
  localparam logic [1:0] WAIT_SCALE_1 = 2'h1;
  localparam logic [1:0] WAIT_SCALE_2 = 2'h2;

  // Quiet time before a clock switch takes effect
  localparam int REF_CLK_MHZ     = 200;
  localparam int SWITCH_QUIET_NS = 40;
  localparam int SWITCH_CYCLES   = (SWITCH_QUIET_NS * REF_CLK_MHZ + 999) / 1000;

  // Clock selection carried as one group
  typedef struct packed {
    logic [1:0] cpu_sel;     // Processor clock code
    logic       bus_fast;    // High when bus runs at 36.864 MHz
    logic [1:0] wait_scale;  // Wait-state scaling, 1 or 2
  } csac_clk_cfg_s;

  // ADC serial configuration carried as one group
  typedef struct packed {
    logic        extended;   // Extended 16-bit config in use
    logic [15:0] data;       // Configuration word to shift out
    logic [4:0]  length;     // Number of bits to shift, 8 to 16
  } csac_adc_cfg_s;

  typedef enum logic [0:0] {
    SW_IDLE   = 1'b0,
    SW_SWITCH = 1'b1
  } csac_sw_state_e;

endpackage

// File: csac_top.sv
// Clock speed select, codec port routing and ADC configuration selection.
// Assumes classic Wishbone master, synchronous inputs and a downstream
// clock generator that switches glitch-free on a change of clk_cfg.
//
// Contract
// RL1: Codec port select set routes multimedia codec port; clear uses serial interface.
// RL2: Extend bit clear takes ADC config only from serial I/O bits 7..0.
// RL3: Extend bit set sends bits 31..16; bits 6..0 give length 8..16.
// RL4: Clock speed select picks processor clock 18.432/36.864/49.152/73.728 MHz.
// RL5: Code 00 gives bus 18.432 MHz scale 1; others 36.864 MHz scale 2.
// RL6: Software keeps clock speed select at 00 when running from 13 MHz.
// RL7: Software changes clock speed select only with unbuffered writes.
// RL8: Clock and wait-state scaling change together on one switch boundary.
//
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module csac_top #(
  parameter int SWITCH_WAIT = csac_pkg::SWITCH_CYCLES
) (
  // Clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Wishbone slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  // Clock generation and wait-state timing
  output csac_pkg::csac_clk_cfg_s     clk_cfg,
  output logic                        switch_busy,
  // Serial port routing and ADC configuration
  output logic                        multimedia_codec_port,
  output csac_pkg::csac_adc_cfg_s     adc_cfg
);

  // Elaboration check: the quiet-time counter is eight bits wide
  if (SWITCH_WAIT < 1 || SWITCH_WAIT > 255) begin : g_bad_wait
    $error("SWITCH_WAIT must lie in 1..255");
  end

  // Map a clock code to its processor and bus settings
  function automatic csac_pkg::csac_clk_cfg_s clk_decode(input logic [1:0] code);
    csac_pkg::csac_clk_cfg_s c;
    c.cpu_sel = code;
    // RL5: bus and scaling
    if (code == 2'h0) begin
      c.bus_fast   = 1'b0;
      c.wait_scale = csac_pkg::WAIT_SCALE_1;
    end else begin
      c.bus_fast   = 1'b1;
      c.wait_scale = csac_pkg::WAIT_SCALE_2;
    end
    return c;
  endfunction

  // Merge write data into a word under byte enables
  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wdat[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register state
  logic                    adc_config_extend_enable;
  logic [1:0]              clock_speed_select;
  logic                    codec_port_select;
  logic [31:0]             sync_serial_io_reg;
  logic                    next_adc_config_extend_enable;
  logic [1:0]              next_clock_speed_select;
  logic                    next_codec_port_select;
  logic [31:0]             next_sync_serial_io_reg;
  logic [31:0]             next_wb_dat_o;
  logic                    next_wb_ack_o;
  logic                    bus_req;
  logic                    bus_wr;
  logic [31:0]             ctrl_word;
  logic [31:0]             ctrl_new;

  assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr    = bus_req && wb_we_i;
  assign ctrl_word = {28'h000_0000, codec_port_select, clock_speed_select, adc_config_extend_enable};
  assign ctrl_new  = byte_merge(ctrl_word, wb_dat_i, wb_sel_i);

  // Bus decode: one-cycle ack, unmapped reads zero, unmapped writes dropped
  always_comb begin
    next_adc_config_extend_enable = adc_config_extend_enable;
    next_clock_speed_select       = clock_speed_select;
    next_codec_port_select        = codec_port_select;
    next_sync_serial_io_reg       = sync_serial_io_reg;
    next_wb_ack_o                 = bus_req;
    next_wb_dat_o                 = 32'h0000_0000;
    if (bus_req) begin
      unique case (wb_adr_i)
        csac_pkg::CTRL_OFFSET: begin
          next_wb_dat_o = ctrl_word;
          if (bus_wr) begin
            next_adc_config_extend_enable = ctrl_new[csac_pkg::ADC_EXT_BIT];
            next_clock_speed_select       = ctrl_new[csac_pkg::CLK_SEL_MSB:csac_pkg::CLK_SEL_LSB];
            next_codec_port_select        = ctrl_new[csac_pkg::CODEC_SEL_BIT];
          end
        end
        csac_pkg::SYNC_SERIAL_IO_REG_OFFSET: begin
          next_wb_dat_o = sync_serial_io_reg;
          if (bus_wr) begin
            next_sync_serial_io_reg = byte_merge(sync_serial_io_reg, wb_dat_i, wb_sel_i);
          end
        end
        csac_pkg::STATUS_OFFSET: begin
          // Shows the code actually in force and whether a switch is pending
          next_wb_dat_o = {27'h000_0000, switch_busy, 2'h0, clk_cfg.cpu_sel};
        end
        default: begin
          next_wb_dat_o = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      adc_config_extend_enable <= csac_pkg::CTRL_RESET[csac_pkg::ADC_EXT_BIT];
      clock_speed_select       <= csac_pkg::CTRL_RESET[csac_pkg::CLK_SEL_MSB:csac_pkg::CLK_SEL_LSB];
      codec_port_select        <= csac_pkg::CTRL_RESET[csac_pkg::CODEC_SEL_BIT];
      sync_serial_io_reg       <= csac_pkg::SYNC_SERIAL_IO_REG_RESET;
      wb_ack_o                 <= 1'b0;
      wb_dat_o                 <= 32'h0000_0000;
    end else begin
      adc_config_extend_enable <= next_adc_config_extend_enable;
      clock_speed_select       <= next_clock_speed_select;
      codec_port_select        <= next_codec_port_select;
      sync_serial_io_reg       <= next_sync_serial_io_reg;
      wb_ack_o                 <= next_wb_ack_o;
      wb_dat_o                 <= next_wb_dat_o;
    end
  end

  // Clock switch sequencer state
  csac_pkg::csac_sw_state_e  sw_state;
  csac_pkg::csac_sw_state_e  next_sw_state;
  logic [7:0]                sw_count;
  logic [7:0]                next_sw_count;
  csac_pkg::csac_clk_cfg_s   next_clk_cfg;
  logic                      next_switch_busy;

  // The code is read when the quiet time ends; a second write
  // during the quiet time is taken up by the switch in progress, with no restart.
  always_comb begin
    next_sw_state    = sw_state;
    next_sw_count    = sw_count;
    next_clk_cfg     = clk_cfg;
    next_switch_busy = 1'b0;
    unique case (sw_state)
      csac_pkg::SW_IDLE: begin
        if (clock_speed_select != clk_cfg.cpu_sel) begin
          next_sw_state    = csac_pkg::SW_SWITCH;
          next_sw_count    = 8'(SWITCH_WAIT - 1);
          next_switch_busy = 1'b1;
        end
      end
      csac_pkg::SW_SWITCH: begin
        next_switch_busy = 1'b1;
        if (sw_count == 8'h00) begin
          // RL8: one boundary
          // RL4: processor clock code
          next_clk_cfg     = clk_decode(clock_speed_select);
          next_sw_state    = csac_pkg::SW_IDLE;
          next_switch_busy = 1'b0;
        end else begin
          next_sw_count = sw_count - 8'h01;
        end
      end
    endcase
  end

  // Clock switch registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sw_state    <= csac_pkg::SW_IDLE;
      sw_count    <= 8'h00;
      clk_cfg     <= {2'h0, 1'b0, csac_pkg::WAIT_SCALE_1};
      switch_busy <= 1'b0;
    end else begin
      sw_state    <= next_sw_state;
      sw_count    <= next_sw_count;
      clk_cfg     <= next_clk_cfg;
      switch_busy <= next_switch_busy;
    end
  end

  // Routing and ADC configuration outputs
  csac_pkg::csac_adc_cfg_s  next_adc_cfg;
  logic                     next_multimedia_codec_port;
  logic [6:0]               len_field;

  assign len_field = sync_serial_io_reg[csac_pkg::LEN_MSB:0];

  // Length outside 8..16 is clamped so the shifter never runs short or long
  always_comb begin
    // RL1: codec port routing
    next_multimedia_codec_port = codec_port_select;
    next_adc_cfg.extended      = adc_config_extend_enable;
    if (adc_config_extend_enable) begin
      // RL3: extended field and length
      next_adc_cfg.data = sync_serial_io_reg[csac_pkg::EXT_CFG_MSB:csac_pkg::EXT_CFG_LSB];
      if (len_field < csac_pkg::LEN_MIN) begin
        next_adc_cfg.length = csac_pkg::LEN_MIN[4:0];
      end else if (len_field > csac_pkg::LEN_MAX) begin
        next_adc_cfg.length = csac_pkg::LEN_MAX[4:0];
      end else begin
        next_adc_cfg.length = len_field[4:0];
      end
    end else begin
      // RL2: config byte only
      next_adc_cfg.data   = {8'h00, sync_serial_io_reg[csac_pkg::CFG_BYTE_MSB:0]};
      next_adc_cfg.length = csac_pkg::LEN_MIN[4:0];
    end
  end

  // Output registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      multimedia_codec_port <= 1'b0;
      adc_cfg               <= {1'b0, 16'h0000, csac_pkg::LEN_MIN[4:0]};
    end else begin
      multimedia_codec_port <= next_multimedia_codec_port;
      adc_cfg               <= next_adc_cfg;
    end
  end

endmodule

// File: csac_top_props.sv
// Assertions on the ports of the clock speed and ADC configuration block.
// Assumes one clock domain, synchronous active-high reset, classic Wishbone.
`timescale 1ns/1ps
module csac_top_props #(
  parameter int SWITCH_WAIT = csac_pkg::SWITCH_CYCLES
) (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [3:0]              wb_adr_i,
  input wire logic [3:0]              wb_sel_i,
  input wire logic [31:0]             wb_dat_i,
  input wire logic [31:0]             wb_dat_o,
  input wire logic                    wb_ack_o,
  input wire csac_pkg::csac_clk_cfg_s clk_cfg,
  input wire logic                    switch_busy,
  input wire logic                    multimedia_codec_port,
  input wire csac_pkg::csac_adc_cfg_s adc_cfg
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [8:0] busy_cnt;
  // Length of the current switch; bounds how long the old clock lingers
  always_ff @(posedge ref_clk) begin
    busy_cnt <= (rst || !switch_busy) ? 9'h000 : busy_cnt + 9'h001;
  end
  // Acked write to the control register with the low byte enabled
  sequence ctrl_wr;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == csac_pkg::CTRL_OFFSET && wb_sel_i[0] && !wb_ack_o ##1 wb_ack_o;
  endsequence
  chk_codec_route: assert property (ctrl_wr |=> multimedia_codec_port == $past(wb_dat_i[3], 2))
    else $error("codec routing does not follow control write");
  chk_base_cfg: assert property (!adc_cfg.extended |-> adc_cfg.length == 5'd8 && adc_cfg.data[15:8] == 8'h00)
    else $error("base ADC config not byte wide");
  chk_ext_len: assert property (adc_cfg.extended |-> adc_cfg.length >= 5'd8 && adc_cfg.length <= 5'd16)
    else $error("extended ADC length out of range");
  chk_scale_match: assert property (clk_cfg.wait_scale == (clk_cfg.cpu_sel == 2'b00 ? 2'h1 : 2'h2))
    else $error("wait scaling does not match clock code");
  chk_bus_speed: assert property (clk_cfg.bus_fast == (clk_cfg.cpu_sel != 2'b00))
    else $error("bus clock does not match clock code");
  chk_switch_edge: assert property ($changed(clk_cfg) |-> $fell(switch_busy))
    else $error("clock config changed off the switch boundary");
  chk_busy_bound: assert property (busy_cnt <= 9'(SWITCH_WAIT + 1))
    else $error("clock switch lasted too long");
  chk_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a one-cycle answer");
  chk_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
endmodule
bind csac_top csac_top_props #(.SWITCH_WAIT(SWITCH_WAIT)) csac_top_props_inst (
  .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .clk_cfg(clk_cfg), .switch_busy(switch_busy), .multimedia_codec_port(multimedia_codec_port), .adc_cfg(adc_cfg));

// File: csac_top_tb.sv
// Self-checking bench for the clock speed and ADC configuration block.
// Assumes the checker is bound in; drives the bus itself with no model.
`timescale 1ns/1ps
module csac_top_tb;
  localparam int SW = 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, busy, codec;
  logic [3:0] adr = 4'h0, sel = 4'h0, wsel = 4'hf;
  logic [31:0] wdat = 32'h0000_0000, rdat, rd;
  csac_pkg::csac_clk_cfg_s clk_cfg;
  csac_pkg::csac_adc_cfg_s adc_cfg;
  int n_errors = 0, total_checks = 0, cycles = 0, busy_n = 0;
  csac_top #(.SWITCH_WAIT(SW)) csac_top_inst (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .clk_cfg(clk_cfg), .switch_busy(busy), .multimedia_codec_port(codec), .adc_cfg(adc_cfg));
  // Clock and hang guard; a long run counts as a mismatch
  initial forever #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  // One classic cycle; request held until ack is sampled high
  // unbuffered writes only
  task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= wsel;
    do @(posedge ref_clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // Let a register write reach the outputs and any clock switch finish
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    while (busy !== 1'b0) @(posedge ref_clk);
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    chk("reset clk_cfg", 32'h0000_0001, 32'(clk_cfg));
    chk("reset adc_cfg", 32'h0000_0008, 32'(adc_cfg));
    chk("reset codec", 32'h0000_0000, 32'(codec));
    // Every clock code, each with bus speed and scaling
    for (int c = 3; c >= 0; c--) begin // the run ends at the default 00
      bus(1'b1, 4'h0, 32'(c << 1));
      @(posedge ref_clk);
      chk("old sel while busy", (c == 3) ? 32'h0000_0000 : 32'(c + 1), 32'(clk_cfg.cpu_sel));
      busy_n = 0;
      // Busy must last exactly the quiet time before the new code lands
      while (busy === 1'b1) begin
        busy_n++;
        @(posedge ref_clk);
      end
      chk("busy cycles", 32'(SW), 32'(busy_n));
      chk("cpu_sel", 32'(c), 32'(clk_cfg.cpu_sel));
      chk("bus_fast", 32'(c != 0), 32'(clk_cfg.bus_fast));
      chk("wait_scale", (c == 0) ? 32'h0000_0001 : 32'h0000_0002, 32'(clk_cfg.wait_scale));
      bus(1'b0, 4'h8, 32'h0000_0000);
      chk("status sel", 32'(c), rd & 32'h0000_0003);
    end
    bus(1'b1, 4'h0, 32'h0000_0008);
    settle();
    chk("codec on", 32'h0000_0001, 32'(codec));
    bus(1'b1, 4'h4, 32'hA5C3_0F2C);
    bus(1'b1, 4'h0, 32'h0000_0000);
    settle();
    chk("codec off", 32'h0000_0000, 32'(codec));
    chk("base cfg", 32'h0000_0588, 32'(adc_cfg));
    bus(1'b1, 4'h0, 32'h0000_0001);
    settle();
    chk("ext clamp hi", 32'h0034_B870, 32'(adc_cfg));
    bus(1'b1, 4'h4, 32'h1234_000C);
    settle();
    chk("ext len 12", 32'h0022_468C, 32'(adc_cfg));
    bus(1'b1, 4'h4, 32'h1234_0003);
    settle();
    chk("ext clamp lo", 32'h0022_4688, 32'(adc_cfg));
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("sync_serial_io_reg read", 32'h1234_0003, rd);
    // Byte lane 1 only; the other lanes must keep their bytes
    wsel = 4'h2;
    bus(1'b1, 4'h4, 32'hFFFF_FFFF);
    wsel = 4'hf;
    bus(1'b0, 4'h4, 32'h0000_0000);
    chk("sync_serial_io_reg byte lane", 32'h1234_FF03, rd);
    // Status is read-only; unmapped writes are dropped
    bus(1'b1, 4'h8, 32'hFFFF_FFFF);
    bus(1'b0, 4'h8, 32'h0000_0000);
    chk("status read-only", 32'h0000_0000, rd);
    bus(1'b0, 4'h0, 32'h0000_0000);
    chk("ctrl read", 32'h0000_0001, rd);
    bus(1'b1, 4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk("unmapped read", 32'h0000_0000, rd);
    end_sim();
  end
endmodule
